// ===== hw/ets_defines.vh
// Constants for the exposure and frame timing sequencer
`ifndef ETS_DEFINES_VH
`define ETS_DEFINES_VH

// Clock rate
`define ETS_CLK_MHZ          32'h000000C8
// Exposure modes
`define ETS_MODE_INT         4'h2
`define ETS_MODE_SMART       4'h4
`define ETS_MODE_FALL        4'h6
`define ETS_MODE_SMART_SEQ   4'h9
`define ETS_MODE_FALL_SEQ    4'hA
`define ETS_MODE_RST         4'h2
// Times in microseconds
`define ETS_READOUT_US       32'h00002710
`define ETS_TRIG_DLY_US      32'h00000064
`define ETS_EXP_MIN_US       32'h00000028
`define ETS_EXP_MAX_US       32'h003D0900
`define ETS_EXP_MIN9_US      32'h0000000A
`define ETS_EXP_MIN10_US     32'h00000007
`define ETS_GAP_US           32'h00000001
`define ETS_SPACING_US       32'h00000096
`define ETS_PERIOD_MAX_US    32'h00989680
// Reset values in microseconds
`define ETS_EXP_RST_US       32'h00002328
`define ETS_PERIOD_RST_US    32'h00002710
// Cycle counts
`define ETS_CYC(us)          ((us) * `ETS_CLK_MHZ)

`endif

// ===== hw/ets_sequencer.v
// Exposure and frame timing sequencer for a global shutter camera
`timescale 1ns/1ps
`include "ets_defines.vh"

module ets_sequencer #(
   parameter [31:0] READOUT_US = `ETS_READOUT_US,
   parameter [31:0] TRIG_DLY_US = `ETS_TRIG_DLY_US,
   parameter [31:0] GAP_US      = `ETS_GAP_US,
   parameter [31:0] SPACING_US  = `ETS_SPACING_US,
   parameter [31:0] CLK_MHZ     = `ETS_CLK_MHZ
) (
   // Clock and reset
   input  wire        ref_clk_in,
   input  wire        rst_b_in,
   // Trigger line
   input  wire        external_sync_trigger_in,
   // Settings from the command parser
   input  wire        mode_wr_in,
   input  wire [3:0]  mode_in,
   input  wire        exp_wr_in,
   input  wire [31:0] exp_us_in,
   input  wire        period_wr_in,
   input  wire [31:0] period_us_in,
   // Status and sensor controls
   output reg  [3:0]  mode_out,
   output reg  [31:0] exp_us_out,
   output reg  [31:0] period_us_out,
   output reg         integrate_out,
   output reg         readout_out,
   output reg         frame_start_out,
   output reg         warn_out,
   output reg         cmd_reject_out
);

   // ==========================================================
   // Helpers
   // ==========================================================
   // Microseconds to clock cycles, kept 40 bits wide
   function [39:0] us2cyc;
      input [31:0] us;
      begin
         us2cyc = {8'h00, us} * {8'h00, CLK_MHZ};
      end
   endfunction

   // Limit a value to a closed range
   function [31:0] clip;
      input [31:0] v;
      input [31:0] lo;
      input [31:0] hi;
      begin
         clip = (v < lo) ? lo : ((v > hi) ? hi : v);
      end
   endfunction

   // Mode is one of the five supported codes
   function legal_mode;
      input [3:0] m;
      begin
         case (m)
            `ETS_MODE_INT,
            `ETS_MODE_SMART,
            `ETS_MODE_FALL,
            `ETS_MODE_SMART_SEQ,
            `ETS_MODE_FALL_SEQ: legal_mode = 1'b1;
            default:            legal_mode = 1'b0;
         endcase
      end
   endfunction

   // Modes in which integration may overlap readout
   function concur_mode;
      input [3:0] m;
      begin
         case (m)
            `ETS_MODE_INT,
            `ETS_MODE_SMART,
            `ETS_MODE_FALL: concur_mode = 1'b1;
            default:        concur_mode = 1'b0;
         endcase
      end
   endfunction

   // Modes that take a programmed exposure time
   function exp_mode;
      input [3:0] m;
      begin
         case (m)
            `ETS_MODE_INT,
            `ETS_MODE_FALL,
            `ETS_MODE_FALL_SEQ: exp_mode = 1'b1;
            default:            exp_mode = 1'b0;
         endcase
      end
   endfunction

   // Shortest exposure allowed in the smart modes; other modes clip exposure writes at ETS_EXP_MIN_US
   function [31:0] min_exp_us;
      input [3:0] m;
      begin
         case (m)
            `ETS_MODE_SMART_SEQ: min_exp_us = `ETS_EXP_MIN9_US;
            `ETS_MODE_FALL_SEQ:  min_exp_us = `ETS_EXP_MIN10_US;
            default:             min_exp_us = `ETS_EXP_MIN_US;
         endcase
      end
   endfunction

   // Fixed times in clock cycles
   localparam [39:0] RD_CYC  = us2cyc(READOUT_US);
   localparam [39:0] DLY_CYC = us2cyc(TRIG_DLY_US);
   localparam [39:0] GAP_CYC = us2cyc(GAP_US);
   localparam [39:0] SP_CYC  = us2cyc(SPACING_US);

   // Exposure states
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_DLY  = 3'h1;
   localparam [2:0] ST_EXP  = 3'h2;
   localparam [2:0] ST_HOLD = 3'h3;
   localparam [2:0] ST_GAP  = 3'h4;

   // ==========================================================
   // Settings
   // ==========================================================
   // Trigger edge detection
   reg        trig_d_r;
   wire       trig_rise = external_sync_trigger_in & ~trig_d_r;
   wire       trig_fall = ~external_sync_trigger_in & trig_d_r;

   wire        mode_ok  = legal_mode(mode_in);
   wire        exp_ok   = exp_mode(mode_out);
   wire [31:0] exp_clip = clip(exp_us_in, `ETS_EXP_MIN_US, `ETS_EXP_MAX_US);
   wire [31:0] per_clip = clip(period_us_in, READOUT_US, `ETS_PERIOD_MAX_US);
   wire        concur   = concur_mode(mode_out);

   // Writes apply in priority mode, exposure, period
   always @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         mode_out       <= `ETS_MODE_RST;
         exp_us_out     <= `ETS_EXP_RST_US;
         period_us_out  <= `ETS_PERIOD_RST_US;
         warn_out       <= 1'b0;
         cmd_reject_out <= 1'b0;
      end else begin
         warn_out       <= 1'b0;
         cmd_reject_out <= 1'b0;
         if (mode_wr_in) begin
            if (mode_ok)
               mode_out <= mode_in;
            else
               cmd_reject_out <= 1'b1;
         end else if (exp_wr_in) begin
            if (!exp_ok) begin
               cmd_reject_out <= 1'b1;
            end else begin
               exp_us_out <= exp_clip;
               if (mode_out == `ETS_MODE_INT && exp_clip > period_us_out) begin
                  period_us_out <= exp_clip;
                  warn_out      <= 1'b1;
               end
               // Whole-microsecond increments already; warn on overlap
               if (!concur && exp_clip + READOUT_US > period_us_out)
                  warn_out <= 1'b1;
            end
         end else if (period_wr_in) begin
            if (mode_out != `ETS_MODE_INT) begin
               cmd_reject_out <= 1'b1;
            end else begin
               period_us_out <= per_clip;
               if (exp_us_out > per_clip) begin
                  exp_us_out <= per_clip;
                  warn_out   <= 1'b1;
               end
            end
         end
      end
   end

   // ==========================================================
   // Readout timer
   // ==========================================================
   reg  [39:0] rd_cnt_r;
   reg  [39:0] per_cnt_r;
   reg  [2:0]  st_r;
   reg  [39:0] cnt_r;
   reg  [39:0] sp_cnt_r;
   reg         start_rd_r;
   reg         armed_r;
   wire        rd_busy = (rd_cnt_r != 40'h0);

   // Readout runs a fixed count once started
   always @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rd_cnt_r    <= 40'h0;
         readout_out <= 1'b0;
      end else begin
         if (start_rd_r)
            rd_cnt_r <= RD_CYC;
         else if (rd_busy)
            rd_cnt_r <= rd_cnt_r - 40'h1;
         readout_out <= start_rd_r | (rd_cnt_r > 40'h1);
      end
   end

   // ==========================================================
   // Exposure sequencer
   // ==========================================================
   // Decoded mode
   wire internal = (mode_out == `ETS_MODE_INT);
   wire smart    = (mode_out == `ETS_MODE_SMART) | (mode_out == `ETS_MODE_SMART_SEQ);
   wire [39:0] exp_cyc = us2cyc(exp_us_out);
   wire [39:0] min_cyc = us2cyc(min_exp_us(mode_out));
   // Trigger accepted only when not busy per mode
   wire can_start = concur ? (sp_cnt_r == 40'h0) : !rd_busy;
   // Start condition per mode
   reg  go;
   always @* begin
      go = 1'b0;
      if (can_start) begin
         if (internal)
            go = (per_cnt_r == 40'h0);
         else if (smart)
            go = trig_rise;
         else
            go = trig_fall;
      end
   end

   always @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         trig_d_r        <= 1'b0;
         st_r            <= ST_IDLE;
         cnt_r           <= 40'h0;
         per_cnt_r       <= 40'h0;
         sp_cnt_r        <= 40'h0;
         armed_r         <= 1'b0;
         start_rd_r      <= 1'b0;
         integrate_out   <= 1'b0;
         frame_start_out <= 1'b0;
      end else begin
         trig_d_r        <= external_sync_trigger_in;
         start_rd_r      <= 1'b0;
         frame_start_out <= 1'b0;
         // Down counters, each stopping at zero
         if (per_cnt_r != 40'h0)
            per_cnt_r <= per_cnt_r - 40'h1;
         if (sp_cnt_r != 40'h0)
            sp_cnt_r <= sp_cnt_r - 40'h1;
         if (cnt_r != 40'h0)
            cnt_r <= cnt_r - 40'h1;
         if (smart && trig_fall && st_r != ST_IDLE)
            armed_r <= 1'b1;
         case (st_r)
            // Wait for the period or a trigger edge
            ST_IDLE: begin
               armed_r <= 1'b0;
               if (go) begin
                  frame_start_out <= 1'b1;
                  if (internal) begin
                     per_cnt_r     <= us2cyc(period_us_out) - 40'h1;
                     integrate_out <= 1'b1;
                     cnt_r         <= exp_cyc;
                     st_r          <= ST_EXP;
                  end else begin
                     cnt_r <= DLY_CYC;
                     st_r  <= ST_DLY;
                  end
               end
            end
            // Fixed delay from trigger to exposure
            ST_DLY: begin
               if (cnt_r == 40'h1) begin
                  integrate_out <= 1'b1;
                  sp_cnt_r      <= SP_CYC;
                  cnt_r         <= smart ? min_cyc : exp_cyc;
                  st_r          <= ST_EXP;
               end
            end
            ST_EXP: begin
               // Smart modes: exposure ends at trigger fall after minimum
               if (cnt_r <= 40'h1 && (!smart || armed_r || !external_sync_trigger_in))
                  st_r <= ST_HOLD;
            end
            // Stretch while the previous readout runs
            ST_HOLD: begin
               if (rd_busy && concur) begin
                  integrate_out <= 1'b1;
               end else begin
                  integrate_out <= 1'b0;
                  start_rd_r    <= 1'b1;
                  cnt_r         <= GAP_CYC;
                  st_r          <= ST_GAP;
               end
            end
            // Short guard before the next trigger
            ST_GAP: begin
               if (cnt_r <= 40'h1)
                  st_r <= ST_IDLE;
            end
            default: st_r <= ST_IDLE;
         endcase

         // A new mode abandons the frame in progress
         if (mode_wr_in && mode_ok) begin
            st_r            <= ST_IDLE;
            cnt_r           <= 40'h0;
            per_cnt_r       <= 40'h0;
            sp_cnt_r        <= 40'h0;
            armed_r         <= 1'b0;
            start_rd_r      <= 1'b0;
            integrate_out   <= 1'b0;
            frame_start_out <= 1'b0;
         end
      end
   end

endmodule

// ===== tb/ets_seq_props.sv
// Port checker for the exposure sequencer
`timescale 1ns/1ps
`include "ets_defines.vh"
module ets_seq_props #(
   parameter [31:0] READOUT_US  = 32'hA,
   parameter [31:0] TRIG_DLY_US = 32'h2,
   parameter [31:0] CLK_MHZ     = 32'hC8
) (
   input logic        ref_clk_in, rst_b_in, external_sync_trigger_in,
   input logic        mode_wr_in, exp_wr_in, period_wr_in,
   input logic [3:0]  mode_in, mode_out,
   input logic [31:0] exp_us_in, period_us_in, exp_us_out, period_us_out,
   input logic        integrate_out, readout_out, frame_start_out, warn_out, cmd_reject_out
);
   localparam int        DLO    = TRIG_DLY_US * CLK_MHZ - 3;
   localparam int        DHI    = TRIG_DLY_US * CLK_MHZ + 3;
   localparam [31:0]     RO_CYC = READOUT_US * CLK_MHZ;
   reg        [31:0]     ro_cnt_r;
   wire                  exp_only = exp_wr_in && !mode_wr_in;
   wire                  per_only = period_wr_in && !mode_wr_in && !exp_wr_in;
   // ==========================================
   // Readout length counter
   always @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) ro_cnt_r <= 32'h0;
      else ro_cnt_r <= readout_out ? ro_cnt_r + 32'h1 : 32'h0;
   end
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rst_b_in);
   sequence s_fall6;
      frame_start_out && mode_out == `ETS_MODE_FALL && !integrate_out;
   endsequence
   sequence s_dly;
      ##[DLO:DHI] $rose(integrate_out);
   endsequence
   // ==========================================
   // Properties
   a_trig_delay: assert property (s_fall6 |-> s_dly)
      else $error("exposure start delay wrong");
   a_mode_take: assert property (mode_wr_in && mode_in == `ETS_MODE_FALL
      |=> mode_out == `ETS_MODE_FALL) else $error("mode not taken");
   a_mode_refuse: assert property (mode_wr_in && mode_in == 4'h3
      |=> cmd_reject_out && $stable(mode_out)) else $error("illegal mode taken");
   a_exp_refuse: assert property (exp_only && (mode_out == 4'h4 || mode_out == 4'h9)
      |=> cmd_reject_out && $stable(exp_us_out)) else $error("exposure not refused");
   a_exp_clip_lo: assert property (exp_only && mode_out == `ETS_MODE_FALL
      && exp_us_in < 32'h28 |=> exp_us_out == 32'h28) else $error("low clip");
   a_exp_clip_hi: assert property (exp_only && mode_out == `ETS_MODE_FALL
      && exp_us_in > 32'h3D0900 |=> exp_us_out == 32'h3D0900) else $error("high clip");
   a_per_refuse: assert property (per_only && mode_out != `ETS_MODE_INT
      |=> cmd_reject_out) else $error("period not refused");
   a_per_floor: assert property (per_only && mode_out == `ETS_MODE_INT
      && period_us_in < READOUT_US |=> period_us_out == READOUT_US) else $error("period floor");
   a_ro_length: assert property ($fell(readout_out) |-> ro_cnt_r == RO_CYC)
      else $error("readout length wrong");
   a_no_overlap: assert property (mode_out == 4'h9 || mode_out == 4'hA
      |-> !(integrate_out && readout_out)) else $error("overlap in sequential mode");
endmodule
bind ets_sequencer ets_seq_props #(.READOUT_US(READOUT_US), .TRIG_DLY_US(TRIG_DLY_US),
   .CLK_MHZ(CLK_MHZ)) u_props (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
   .external_sync_trigger_in(external_sync_trigger_in), .mode_wr_in(mode_wr_in),
   .exp_wr_in(exp_wr_in), .period_wr_in(period_wr_in), .mode_in(mode_in),
   .mode_out(mode_out), .exp_us_in(exp_us_in), .period_us_in(period_us_in),
   .exp_us_out(exp_us_out), .period_us_out(period_us_out), .integrate_out(integrate_out),
   .readout_out(readout_out), .frame_start_out(frame_start_out), .warn_out(warn_out),
   .cmd_reject_out(cmd_reject_out));

// ===== tb/ets_trig_src.sv
// Trigger source model standing in for the frame grabber
`timescale 1ns/1ps
module ets_trig_src (
   input  wire        ref_clk_in,
   input  wire        fire_in,
   input  wire [31:0] high_cyc_in,
   output reg         trig_out
);
   reg [31:0] cnt_r = 32'h0;
   // New pulse only once the last one is over
   always @(posedge ref_clk_in) begin
      if (fire_in && cnt_r == 32'h0) cnt_r <= high_cyc_in;
      else if (cnt_r != 32'h0) cnt_r <= cnt_r - 32'h1;
   end
   initial trig_out = 1'b0;
   always @(negedge ref_clk_in) trig_out <= (cnt_r != 32'h0);
endmodule

// ===== tb/ets_sequencer_test.sv
// Self-checking bench for the exposure sequencer
`timescale 1ns/1ps
`include "ets_defines.vh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_total++; \
   $display("[ERR] %0t mismatch %h %h", $time, (a), (b)); end end
module ets_sequencer_test;
   reg        ref_clk_in = 1'b0, rst_b_in = 1'b0, fire = 1'b0, rj, wn;
   reg        mode_wr_in = 1'b0, exp_wr_in = 1'b0, period_wr_in = 1'b0;
   reg [3:0]  mode_in = 4'h0;
   reg [31:0] exp_us_in = 32'h0, period_us_in = 32'h0, hi_cyc = 32'h0;
   wire       trig, integrate_out, readout_out, frame_start_out, warn_out, cmd_reject_out;
   wire [3:0] mode_out;
   wire [31:0] exp_us_out, period_us_out;
   int        err_total = 0, checks = 0, fs_cnt = 0, n;
   always #2.5 ref_clk_in = ~ref_clk_in;
   always @(posedge ref_clk_in) if (frame_start_out === 1'b1) fs_cnt++;
   ets_sequencer #(.READOUT_US(32'hA), .TRIG_DLY_US(32'h2), .GAP_US(32'h1),
      .SPACING_US(32'h3)) DUT (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
      .external_sync_trigger_in(trig), .mode_wr_in(mode_wr_in), .mode_in(mode_in),
      .exp_wr_in(exp_wr_in), .exp_us_in(exp_us_in), .period_wr_in(period_wr_in),
      .period_us_in(period_us_in), .mode_out(mode_out), .exp_us_out(exp_us_out),
      .period_us_out(period_us_out), .integrate_out(integrate_out),
      .readout_out(readout_out), .frame_start_out(frame_start_out),
      .warn_out(warn_out), .cmd_reject_out(cmd_reject_out));
   ets_trig_src u_src (.ref_clk_in(ref_clk_in), .fire_in(fire), .high_cyc_in(hi_cyc),
      .trig_out(trig));
   // ==========================================
   // Shared drivers
   task wr(input int k, input [31:0] v);
      @(negedge ref_clk_in);
      mode_in = v[3:0]; exp_us_in = v; period_us_in = v;
      mode_wr_in = (k == 0); exp_wr_in = (k == 1); period_wr_in = (k == 2);
      @(negedge ref_clk_in);
      mode_wr_in = 1'b0; exp_wr_in = 1'b0; period_wr_in = 1'b0;
      rj = cmd_reject_out; wn = warn_out;
   endtask
   task pulse(input [31:0] hi);
      @(negedge ref_clk_in); hi_cyc = hi; fire = 1'b1;
      @(negedge ref_clk_in); fire = 1'b0;
   endtask
   task wt(input int c); repeat (c) @(negedge ref_clk_in); endtask
   task results;
      if (err_total == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // ==========================================
   // Scenarios
   task t_reset;
      `CHK(mode_out, `ETS_MODE_RST)
      `CHK(exp_us_out, 32'h2328)
      `CHK(period_us_out, 32'h2710)
   endtask
   task t_modes;
      reg [3:0] m [5];
      m = '{`ETS_MODE_INT, `ETS_MODE_SMART, `ETS_MODE_FALL, `ETS_MODE_SMART_SEQ,
            `ETS_MODE_FALL_SEQ};
      foreach (m[i]) begin
         wr(0, {28'h0, m[i]}); `CHK(mode_out, m[i])
         `CHK(rj, 1'b0)
      end
      wr(0, 32'h3); `CHK(rj, 1'b1)
      `CHK(mode_out, `ETS_MODE_FALL_SEQ)
   endtask
   task t_exp;
      wr(0, 32'h4); wr(1, 32'h1388); `CHK(rj, 1'b1)
      wr(0, 32'h9); wr(1, 32'h1388); `CHK(rj, 1'b1)
      wr(0, 32'h6); wr(1, 32'h5); `CHK(exp_us_out, 32'h28)
      wr(1, 32'hFFFFFFFF); `CHK(exp_us_out, 32'h3D0900)
      wr(0, 32'hA); wr(1, 32'h64); `CHK(exp_us_out, 32'h64)
   endtask
   task t_fall6;
      wr(0, 32'h6); wr(1, 32'h28); wt(20000); n = fs_cnt;
      pulse(32'hC8); wt(500); `CHK(integrate_out, 1'b0)
      wt(200); `CHK(integrate_out, 1'b1)
      `CHK(fs_cnt, n + 1)
      wt(7900); `CHK(integrate_out, 1'b1)
      wt(300); `CHK(integrate_out, 1'b0)
      `CHK(readout_out, 1'b1)
      wt(2500);
   endtask
   task t_smart4;
      wr(0, 32'h4); pulse(32'h2710); wt(500); `CHK(integrate_out, 1'b1)
      wt(10100); `CHK(readout_out, 1'b1)
      `CHK(integrate_out, 1'b0)
      wt(3000);
   endtask
   task t_seq9;
      wr(0, 32'h9); pulse(32'h7D0); wt(2600); `CHK(readout_out, 1'b1)
      n = fs_cnt; pulse(32'h64); wt(3000); `CHK(fs_cnt, n)
   endtask
   task t_fall10;
      wr(0, 32'hA); pulse(32'hC8); wt(500); `CHK(integrate_out, 1'b0)
      wt(200); `CHK(integrate_out, 1'b1)
      wt(8200); `CHK(integrate_out, 1'b0)
      `CHK(readout_out, 1'b1)
      wt(2500);
   endtask
   task t_period;
      wr(0, 32'h6); wr(2, 32'h4E20); `CHK(rj, 1'b1)
      wr(0, 32'h2); wr(2, 32'h5); `CHK(period_us_out, 32'hA)
      wr(1, 32'hC350); `CHK(period_us_out >= 32'hC350, 1'b1)
      `CHK(wn, 1'b1)
      wr(2, 32'h4E20); `CHK(exp_us_out <= 32'h4E20, 1'b1)
      `CHK(wn, 1'b1)
      wr(0, 32'hA); wr(1, 32'h4E20); `CHK(wn, 1'b1)
      `CHK(exp_us_out, 32'h4E20)
   endtask
   initial begin
      repeat (100000) @(posedge ref_clk_in);
      err_total++;
      results;
   end
   initial begin
      repeat (12) @(posedge ref_clk_in);
      @(negedge ref_clk_in) rst_b_in = 1'b1;
      wt(1);
      t_reset; t_modes; t_exp; t_fall6; t_smart4; t_seq9; t_fall10; t_period;
      results;
   end
endmodule
